// ---- design/fwsr_pkg.sv ----
// constants for the flash write-status host controller
package fwsr_pkg;
   // clock and bus timing
   localparam int CLK_MHZ = 50;
   localparam int T_SETUP_NS = 20;
   localparam int T_STROBE_NS = 100;
   localparam int T_RECOVER_NS = 40;
   localparam int T_ERASE_GAP_US = 50;

   // least times round up, never below one cycle
   function automatic int ns2cyc(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction : ns2cyc

   localparam int SETUP_CYC = ns2cyc(T_SETUP_NS);
   localparam int STROBE_CYC = ns2cyc(T_STROBE_NS);
   localparam int RECOVER_CYC = ns2cyc(T_RECOVER_NS);
   // longest time, rounds down
   localparam int GAP_CYC = T_ERASE_GAP_US * CLK_MHZ;

   // register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_RDATA = 8'h10;

   // control bits (write-only pulses)
   localparam int CTRL_WRITE = 0;
   localparam int CTRL_POLL = 1;
   localparam int CTRL_READ = 2;
   localparam int CTRL_ABORT = 3;

   // status bits; done and fail are write-one-to-clear
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_FAIL = 2;
   localparam int ST_READY = 3;
   localparam int ST_WINDOW = 4;
   localparam int ST_GAP_OK = 5;
   localparam int ST_TOGGLE_B = 6;

   // positions on the data lines
   localparam int DQ_TOGGLE_A = 6;
   localparam int DQ_TIME_LIMIT = 5;
   localparam int DQ_WINDOW = 3;
   localparam int DQ_TOGGLE_B = 2;

   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;

   // poll sequencer states
   typedef enum logic [6:0] {
      FWSR_IDLE = 7'h01,
      FWSR_WR = 7'h02,
      FWSR_RD = 7'h04,
      FWSR_P1 = 7'h08,
      FWSR_P2 = 7'h10,
      FWSR_P3 = 7'h20,
      FWSR_P4 = 7'h40
   } fwsr_state_t;

   // bus cycle phases
   typedef enum logic [3:0] {
      FWSR_CY_IDLE = 4'h1,
      FWSR_CY_SETUP = 4'h2,
      FWSR_CY_STROBE = 4'h4,
      FWSR_CY_RECOVER = 4'h8
   } fwsr_phase_t;
endpackage : fwsr_pkg

// ---- design/fwsr_bus_cycle.sv ----
// one asynchronous byte read or write cycle on the flash pins
`timescale 1ns/1ns
module fwsr_bus_cycle #(
   parameter int AW = 22
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // request side
   input wire logic start_i,
   input wire logic write_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic busy_o,
   output logic done_o,
   output logic [7:0] rdata_o,
   // flash pins
   output logic [AW-1:0] addr_o,
   input wire logic [7:0] data_lines_i,
   output logic [7:0] data_lines_o,
   output logic data_lines_oe_o,
   output logic chip_select_n_o,
   output logic output_strobe_n_o,
   output logic write_strobe_n_o
);
   fwsr_pkg::fwsr_phase_t phase, next_phase;
   logic [7:0] cnt, next_cnt;
   logic is_wr, next_is_wr;
   logic [AW-1:0] next_addr;
   logic [7:0] next_wdata, next_rdata;
   logic next_done;
   logic [7:0] dq_meta, dq_sync;

   // pad data is asynchronous: two flops before capture
   always_ff @(posedge clk_i) begin
      dq_meta <= data_lines_i;
      dq_sync <= dq_meta;
   end

   // phase sequencing
   always_comb begin
      next_phase = phase;
      next_cnt = cnt;
      next_is_wr = is_wr;
      next_addr = addr_o;
      next_wdata = data_lines_o;
      next_rdata = rdata_o;
      next_done = 1'b0;
      case (phase)
         fwsr_pkg::FWSR_CY_IDLE: begin
            if (start_i) begin
               next_phase = fwsr_pkg::FWSR_CY_SETUP;
               next_cnt = 8'(fwsr_pkg::SETUP_CYC - 1);
               next_is_wr = write_i;
               next_addr = addr_i;
               next_wdata = wdata_i;
            end
         end
         fwsr_pkg::FWSR_CY_SETUP: begin
            if (cnt == 8'h00) begin
               next_phase = fwsr_pkg::FWSR_CY_STROBE;
               next_cnt = 8'(fwsr_pkg::STROBE_CYC - 1);
            end else begin
               next_cnt = cnt - 8'h01;
            end
         end
         fwsr_pkg::FWSR_CY_STROBE: begin
            if (cnt == 8'h00) begin
               // strobe long enough to cover access plus sync latency
               if (!is_wr) begin
                  next_rdata = dq_sync;
               end
               next_phase = fwsr_pkg::FWSR_CY_RECOVER;
               next_cnt = 8'(fwsr_pkg::RECOVER_CYC - 1);
            end else begin
               next_cnt = cnt - 8'h01;
            end
         end
         fwsr_pkg::FWSR_CY_RECOVER: begin
            if (cnt == 8'h00) begin
               next_phase = fwsr_pkg::FWSR_CY_IDLE;
               next_done = 1'b1;
            end else begin
               next_cnt = cnt - 8'h01;
            end
         end
         default: begin
            next_phase = fwsr_pkg::FWSR_CY_IDLE;
         end
      endcase
   end

   // pins are registered so no glitch reaches the flash
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase <= fwsr_pkg::FWSR_CY_IDLE;
         cnt <= 8'h00;
         is_wr <= 1'b0;
         addr_o <= '0;
         data_lines_o <= fwsr_pkg::RST_BYTE;
         rdata_o <= fwsr_pkg::RST_BYTE;
         done_o <= 1'b0;
         busy_o <= 1'b0;
         data_lines_oe_o <= 1'b0;
         chip_select_n_o <= 1'b1;
         output_strobe_n_o <= 1'b1;
         write_strobe_n_o <= 1'b1;
      end else begin
         phase <= next_phase;
         cnt <= next_cnt;
         is_wr <= next_is_wr;
         addr_o <= next_addr;
         data_lines_o <= next_wdata;
         rdata_o <= next_rdata;
         done_o <= next_done;
         busy_o <= (next_phase != fwsr_pkg::FWSR_CY_IDLE);
         // data held through recover for write hold time
         data_lines_oe_o <= next_is_wr && (next_phase != fwsr_pkg::FWSR_CY_IDLE);
         chip_select_n_o <= (next_phase == fwsr_pkg::FWSR_CY_IDLE);
         // each read is a full strobe pulse so toggle bits advance
         output_strobe_n_o <= !(next_phase == fwsr_pkg::FWSR_CY_STROBE && !next_is_wr);
         // commands latch on the strobe rising edge
         write_strobe_n_o <= !(next_phase == fwsr_pkg::FWSR_CY_STROBE && next_is_wr);
      end
   end
endmodule : fwsr_bus_cycle

// ---- design/fwsr_host.sv ----
// host controller: apb registers, flash cycles and toggle-bit polling
//
// How it works
// - host reads twice, compares toggle bit
// - toggling with time limit: recheck, then fail
// - abandoned polling restarts from first step
// - after failure only reset command helps
// - host checks window flag around extra erases
// - extra sector loads within 50us
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module fwsr_host #(
   parameter int AW = 22
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // flash pins
   output logic [AW-1:0] addr_o,
   input wire logic [7:0] data_lines_i,
   output logic [7:0] data_lines_o,
   output logic data_lines_oe_o,
   output logic chip_select_n_o,
   output logic output_strobe_n_o,
   output logic write_strobe_n_o,
   input wire logic ready_busy_output_i
);
   fwsr_pkg::fwsr_state_t state, next_state;
   logic [AW-1:0] addr_reg, next_addr_reg;
   logic [7:0] wdata_reg, next_wdata_reg;
   logic [7:0] last_rd, next_last_rd;
   logic [7:0] first_rd, next_first_rd;
   logic done_flag, next_done_flag;
   logic fail_flag, next_fail_flag;
   logic tog_b, next_tog_b;
   logic start, next_start;
   logic start_wr, next_start_wr;
   logic [11:0] gap_cnt, next_gap_cnt;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   logic rb_meta, rb_sync;
   logic cyc_busy, cyc_done;
   logic [7:0] cyc_rdata;
   logic wr_acc, ctrl_wr, ready_to_start;

   // returns 1 when the two reads differ on the given bit
   function automatic logic bit_moved(input logic [7:0] a, input logic [7:0] b, input int pos);
      return a[pos] ^ b[pos];
   endfunction : bit_moved

   // ready line is an open-drain pin from outside: synchronise
   always_ff @(posedge clk_i) begin
      rb_meta <= ready_busy_output_i;
      rb_sync <= rb_meta;
   end

   fwsr_bus_cycle #(
      .AW(AW)
   ) u_cycle (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(start),
      .write_i(start_wr),
      .addr_i(addr_reg),
      .wdata_i(wdata_reg),
      .busy_o(cyc_busy),
      .done_o(cyc_done),
      .rdata_o(cyc_rdata),
      .addr_o(addr_o),
      .data_lines_i(data_lines_i),
      .data_lines_o(data_lines_o),
      .data_lines_oe_o(data_lines_oe_o),
      .chip_select_n_o(chip_select_n_o),
      .output_strobe_n_o(output_strobe_n_o),
      .write_strobe_n_o(write_strobe_n_o)
   );

   assign wr_acc = psel_i && penable_i && pready_o && pwrite_i;
   assign ctrl_wr = wr_acc && (paddr_i == fwsr_pkg::REG_CTRL);
   // new orders only when nothing is in flight; otherwise ignored
   assign ready_to_start = (state == fwsr_pkg::FWSR_IDLE) && !cyc_busy && !start;

   // sequencer and polling algorithm
   always_comb begin
      next_state = state;
      next_addr_reg = addr_reg;
      next_wdata_reg = wdata_reg;
      next_last_rd = last_rd;
      next_first_rd = first_rd;
      next_done_flag = done_flag;
      next_fail_flag = fail_flag;
      next_tog_b = tog_b;
      next_start = 1'b0;
      next_start_wr = start_wr;
      next_gap_cnt = gap_cnt;
      if (gap_cnt != 12'(fwsr_pkg::GAP_CYC)) begin
         next_gap_cnt = gap_cnt + 12'h001;
      end
      if (wr_acc && paddr_i == fwsr_pkg::REG_ADDR) begin
         next_addr_reg = pwdata_i[AW-1:0];
      end
      if (wr_acc && paddr_i == fwsr_pkg::REG_WDATA) begin
         next_wdata_reg = pwdata_i[7:0];
      end
      // write-one-to-clear; a set below in the same cycle wins
      if (wr_acc && paddr_i == fwsr_pkg::REG_STATUS) begin
         if (pwdata_i[fwsr_pkg::ST_DONE]) begin
            next_done_flag = 1'b0;
         end
         if (pwdata_i[fwsr_pkg::ST_FAIL]) begin
            next_fail_flag = 1'b0;
         end
      end
      case (state)
         fwsr_pkg::FWSR_IDLE: begin
            if (ctrl_wr && ready_to_start) begin
               if (pwdata_i[fwsr_pkg::CTRL_WRITE]) begin
                  // reset command after a failure is just a write sequence
                  next_state = fwsr_pkg::FWSR_WR;
                  next_start = 1'b1;
                  next_start_wr = 1'b1;
               end else if (pwdata_i[fwsr_pkg::CTRL_POLL]) begin
                  next_state = fwsr_pkg::FWSR_P1;
                  next_start = 1'b1;
                  next_start_wr = 1'b0;
               end else if (pwdata_i[fwsr_pkg::CTRL_READ]) begin
                  next_state = fwsr_pkg::FWSR_RD;
                  next_start = 1'b1;
                  next_start_wr = 1'b0;
               end
            end
         end
         fwsr_pkg::FWSR_WR: begin
            if (cyc_done) begin
               next_state = fwsr_pkg::FWSR_IDLE;
               next_done_flag = 1'b1;
               // spacing of extra erase loads is timed from here
               next_gap_cnt = 12'h000;
            end
         end
         fwsr_pkg::FWSR_RD: begin
            if (cyc_done) begin
               next_state = fwsr_pkg::FWSR_IDLE;
               next_last_rd = cyc_rdata;
               next_done_flag = 1'b1;
            end
         end
         fwsr_pkg::FWSR_P1, fwsr_pkg::FWSR_P3: begin
            if (cyc_done) begin
               next_first_rd = cyc_rdata;
               next_last_rd = cyc_rdata;
               next_state = (state == fwsr_pkg::FWSR_P1) ? fwsr_pkg::FWSR_P2
                                                         : fwsr_pkg::FWSR_P4;
               next_start = 1'b1;
            end
         end
         fwsr_pkg::FWSR_P2: begin
            if (cyc_done) begin
               next_last_rd = cyc_rdata;
               next_tog_b = bit_moved(first_rd, cyc_rdata, fwsr_pkg::DQ_TOGGLE_B);
               if (!bit_moved(first_rd, cyc_rdata, fwsr_pkg::DQ_TOGGLE_A)) begin
                  next_state = fwsr_pkg::FWSR_IDLE;
                  next_done_flag = 1'b1;
               end else if (cyc_rdata[fwsr_pkg::DQ_TIME_LIMIT]) begin
                  // toggling may have stopped just as the flag rose
                  next_state = fwsr_pkg::FWSR_P3;
                  next_start = 1'b1;
               end else begin
                  // keep monitoring with a fresh pair of reads
                  next_state = fwsr_pkg::FWSR_P1;
                  next_start = 1'b1;
               end
            end
         end
         fwsr_pkg::FWSR_P4: begin
            if (cyc_done) begin
               next_last_rd = cyc_rdata;
               next_state = fwsr_pkg::FWSR_IDLE;
               if (bit_moved(first_rd, cyc_rdata, fwsr_pkg::DQ_TOGGLE_A)) begin
                  next_fail_flag = 1'b1;
               end else begin
                  next_done_flag = 1'b1;
               end
            end
         end
         default: begin
            next_state = fwsr_pkg::FWSR_IDLE;
         end
      endcase
      // abort drops the poll; next poll starts over from the first pair
      if (ctrl_wr && pwdata_i[fwsr_pkg::CTRL_ABORT] && state != fwsr_pkg::FWSR_WR) begin
         next_state = fwsr_pkg::FWSR_IDLE;
         next_start = 1'b0;
      end
   end

   // apb answer: registered, ready in the first access cycle, no wait state
   always_comb begin
      next_pready = psel_i && !penable_i;
      next_pslverr = 1'b0;
      next_prdata = 32'h0000_0000;
      if (psel_i && !penable_i) begin
         case (paddr_i)
            fwsr_pkg::REG_CTRL: next_prdata = 32'h0000_0000;
            fwsr_pkg::REG_ADDR: next_prdata = 32'(addr_reg);
            fwsr_pkg::REG_WDATA: next_prdata = 32'(wdata_reg);
            fwsr_pkg::REG_STATUS: begin
               next_prdata[fwsr_pkg::ST_BUSY] = (state != fwsr_pkg::FWSR_IDLE) || cyc_busy;
               next_prdata[fwsr_pkg::ST_DONE] = done_flag;
               next_prdata[fwsr_pkg::ST_FAIL] = fail_flag;
               next_prdata[fwsr_pkg::ST_READY] = rb_sync;
               next_prdata[fwsr_pkg::ST_WINDOW] = last_rd[fwsr_pkg::DQ_WINDOW];
               next_prdata[fwsr_pkg::ST_GAP_OK] = gap_cnt < 12'(fwsr_pkg::GAP_CYC);
               next_prdata[fwsr_pkg::ST_TOGGLE_B] = tog_b;
            end
            fwsr_pkg::REG_RDATA: next_prdata = 32'(last_rd);
            default: next_pslverr = 1'b1;
         endcase
      end
   end

   // state registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= fwsr_pkg::FWSR_IDLE;
         addr_reg <= '0;
         wdata_reg <= fwsr_pkg::RST_BYTE;
         last_rd <= fwsr_pkg::RST_BYTE;
         first_rd <= fwsr_pkg::RST_BYTE;
         done_flag <= 1'b0;
         fail_flag <= 1'b0;
         tog_b <= 1'b0;
         start <= 1'b0;
         start_wr <= 1'b0;
         gap_cnt <= 12'(fwsr_pkg::GAP_CYC);
         prdata_o <= 32'h0000_0000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         state <= next_state;
         addr_reg <= next_addr_reg;
         wdata_reg <= next_wdata_reg;
         last_rd <= next_last_rd;
         first_rd <= next_first_rd;
         done_flag <= next_done_flag;
         fail_flag <= next_fail_flag;
         tog_b <= next_tog_b;
         start <= next_start;
         start_wr <= next_start_wr;
         gap_cnt <= next_gap_cnt;
         prdata_o <= next_prdata;
         pready_o <= next_pready;
         pslverr_o <= next_pslverr;
      end
   end
endmodule : fwsr_host

// ---- testbench/fwsr_host_chk.sv ----
// port checks for the flash write-status host
`timescale 1ns/1ns
module fwsr_host_chk #(
   parameter int AW = 22
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // apb
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // flash pins
   input wire logic [AW-1:0] addr_o,
   input wire logic [7:0] data_lines_i,
   input wire logic [7:0] data_lines_o,
   input wire logic data_lines_oe_o,
   input wire logic chip_select_n_o,
   input wire logic output_strobe_n_o,
   input wire logic write_strobe_n_o,
   input wire logic ready_busy_output_i
);
   default clocking cb @(posedge clk_i);
   endclocking
   // offsets that answer without error
   wire logic mapped = paddr_i inside {fwsr_pkg::REG_CTRL, fwsr_pkg::REG_ADDR,
      fwsr_pkg::REG_WDATA, fwsr_pkg::REG_STATUS, fwsr_pkg::REG_RDATA};

   // steps of a flash cycle and of a poll start
   sequence s_rd_low;
      (!output_strobe_n_o)[*5] ##1 output_strobe_n_o;
   endsequence
   sequence s_wr_low;
      (!write_strobe_n_o && data_lines_oe_o && $stable(data_lines_o))[*5] ##1 write_strobe_n_o;
   endsequence
   sequence s_poll_req;
      psel_i && penable_i && pready_o && pwrite_i && paddr_i == fwsr_pkg::REG_CTRL
         && pwdata_i[3:0] == 4'h2;
   endsequence
   sequence s_read_pair;
      ##[1:4] $fell(output_strobe_n_o) ##[8:12] $fell(output_strobe_n_o);
   endsequence

   a_poll_pair: assert property (disable iff (rst_i) s_poll_req |-> s_read_pair)
      else $error("poll did not start with two reads");
   a_read_pulse: assert property (disable iff (rst_i) $fell(output_strobe_n_o) |-> s_rd_low)
      else $error("read strobe width wrong");
   a_write_pulse: assert property (disable iff (rst_i) $fell(write_strobe_n_o) |-> s_wr_low)
      else $error("write strobe or data wrong");
   a_pready_next: assert property (disable iff (rst_i) psel_i && !penable_i |=> pready_o)
      else $error("no answer after setup");
   a_pready_once: assert property (disable iff (rst_i) pready_o |=> !pready_o)
      else $error("pready longer than one cycle");
   a_unmapped_err: assert property (disable iff (rst_i)
      psel_i && !penable_i && !mapped |=> pslverr_o && prdata_o == 32'h00000000)
      else $error("stray address not refused");
   a_mapped_ok: assert property (disable iff (rst_i) psel_i && !penable_i && mapped |=> !pslverr_o)
      else $error("mapped address refused");
   a_strobe_select: assert property (disable iff (rst_i)
      !output_strobe_n_o || !write_strobe_n_o |-> !chip_select_n_o && data_lines_oe_o == !write_strobe_n_o)
      else $error("strobe without select or bus clash");
   a_addr_held: assert property (disable iff (rst_i)
      !chip_select_n_o && $past(!chip_select_n_o) |-> $stable(addr_o))
      else $error("address moved inside a cycle");
   a_reset_idle: assert property (rst_i |=> chip_select_n_o && output_strobe_n_o && !pready_o)
      else $error("pins not idle after reset");
endmodule : fwsr_host_chk

bind fwsr_host fwsr_host_chk #(.AW(AW)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .addr_o(addr_o), .data_lines_i(data_lines_i), .data_lines_o(data_lines_o),
   .data_lines_oe_o(data_lines_oe_o), .chip_select_n_o(chip_select_n_o),
   .output_strobe_n_o(output_strobe_n_o), .write_strobe_n_o(write_strobe_n_o),
   .ready_busy_output_i(ready_busy_output_i));

// ---- testbench/fwsr_flash_model.sv ----
// behavioural flash device answering the host's cycles
`timescale 1ns/1ns
module fwsr_flash_model (
   // flash pins
   input wire logic cs_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [21:0] addr_i,
   input wire logic [7:0] dq_i,
   output logic [7:0] dq_o,
   output logic rb_low_o
);
   // set by the bench before each command
   int cfg_cnt = 0;
   logic cfg_q5 = 1'b0;
   logic cfg_er = 1'b0;
   int cnt = 0;
   logic q5 = 1'b0;
   logic er = 1'b0;
   logic tog_a = 1'b0;
   logic tog_b = 1'b0;
   logic [21:0] wr_addr = 22'h000000;
   logic [7:0] mem = 8'h00;
   logic [7:0] last = 8'h00;

   // command taken at the closing write strobe, status valid from here
   always @(posedge we_n_i) begin
      // a busy erase or a timed-out part takes only the reset command
      if (!cs_n_i && (dq_i == 8'hF0 || cnt == 0 || !(er || q5))) begin
         wr_addr = addr_i;
         cnt = (dq_i == 8'hF0) ? 0 : cfg_cnt; // reset command frees a stuck part
         q5 = cfg_q5 && dq_i != 8'hF0;
         er = cfg_er;
         if (dq_i != 8'hF0) begin
            mem = dq_i;
         end
      end
   end

   // tog_a flips once per completed read while busy, tog_b only while erasing
   always @(posedge oe_n_i) begin
      last = dq_o;
      if (!cs_n_i && cnt > 0) begin
         tog_a = ~tog_a;
         tog_b = tog_b ^ er;
         cnt = cnt - 1;
      end
   end

   // released bus shows the inverse of its last value, never a stale copy
   always @* begin
      if (cs_n_i || oe_n_i) begin
         dq_o = ~last;
      end else if (cnt > 0) begin
         dq_o = {~mem[7] & ~er, tog_a, q5, 1'b0, er, tog_b, 2'b00};
      end else begin
         dq_o = mem;
      end
   end
   assign rb_low_o = (cnt > 0); // sinks the line while busy
endmodule : fwsr_flash_model

// ---- testbench/tb_fwsr_host.sv ----
// self-checking bench for the flash write-status host
`timescale 1ns/1ns
module tb_fwsr_host;
   localparam logic [7:0] ST = fwsr_pkg::REG_STATUS;
   localparam logic [7:0] CT = fwsr_pkg::REG_CTRL;
   localparam logic [32:0] ERR = 33'h100000000;
   localparam logic [32:0] M_BSY = 33'h1 << fwsr_pkg::ST_BUSY;
   localparam logic [32:0] M_DN = 33'h1 << fwsr_pkg::ST_DONE;
   localparam logic [32:0] M_FL = 33'h1 << fwsr_pkg::ST_FAIL;
   localparam logic [32:0] M_RDY = 33'h1 << fwsr_pkg::ST_READY;
   localparam logic [32:0] M_WIN = 33'h1 << fwsr_pkg::ST_WINDOW;
   localparam logic [32:0] M_GAP = 33'h1 << fwsr_pkg::ST_GAP_OK;
   localparam logic [32:0] M_TGB = 33'h1 << fwsr_pkg::ST_TOGGLE_B;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h00000000;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, data_lines_oe_o;
   logic chip_select_n_o, output_strobe_n_o, write_strobe_n_o;
   logic [21:0] addr_o;
   logic [7:0] data_lines_o;
   wire logic [7:0] m_dq;
   wire logic m_rb_low;
   // shared bus and pulled-up ready line resolved from all drivers
   wire logic [7:0] data_lines_i = data_lines_oe_o ? data_lines_o : m_dq;
   wire logic ready_busy_output_i = !m_rb_low;
   logic [65:0] exp_q[$];
   logic [31:0] seed = 32'h00000025;
   int n_mismatch = 0;
   int checks_done = 0;
   int cycles = 0;
   // even counts for the finishing cases so no read pair straddles the end of toggling; 99999 outlasts the poll
   int rc[5] = '{0, 4, 2, 99999, 99999};
   logic [4:0] rq = 5'b11100;
   logic [4:0] re = 5'b10000;

   always #10 clk_i = ~clk_i;

   fwsr_host #(.AW(22)) DUT (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .addr_o(addr_o),
      .data_lines_i(data_lines_i), .data_lines_o(data_lines_o),
      .data_lines_oe_o(data_lines_oe_o), .chip_select_n_o(chip_select_n_o),
      .output_strobe_n_o(output_strobe_n_o), .write_strobe_n_o(write_strobe_n_o),
      .ready_busy_output_i(ready_busy_output_i));
   fwsr_flash_model flash (.cs_n_i(chip_select_n_o), .oe_n_i(output_strobe_n_o),
      .we_n_i(write_strobe_n_o), .addr_i(addr_o), .dq_i(data_lines_o), .dq_o(m_dq),
      .rb_low_o(m_rb_low));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic check(input logic [32:0] seen, input logic [32:0] want);
      checks_done++;
      if (seen !== want) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic close_out;
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out

   // a hang counts as a mismatch
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         $display("wrong value at %0t: run timed out", $time);
         close_out();
      end
   end

   // read answers matched in order against the noted expectations
   always @(posedge clk_i) begin
      logic [65:0] e;
      if (psel_i && penable_i && pready_o && !pwrite_i && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         if (e[32:0] != 33'h0) check({pslverr_o, prdata_o} & e[32:0], e[65:33] & e[32:0]);
      end
   end

   // one apb transfer; request held until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [32:0] e, input logic [32:0] m, output logic [31:0] r);
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      if (!w) exp_q.push_back({e, m});
      @(posedge clk_i);
      penable_i <= 1'b1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      r = prdata_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, 33'h0, 33'h0, r);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
      logic [31:0] r;
      apb(1'b0, a, 32'h00000000, e, m, r);
   endtask : rd

   // bounded wait for the busy flag to drop
   task automatic wait_idle;
      logic [31:0] r;
      int k;
      k = 0;
      r = 32'h00000001;
      while (r[0] !== 1'b0 && k < 400) begin
         apb(1'b0, ST, 32'h00000000, 33'h0, 33'h0, r);
         k++;
      end
      check({32'h00000000, r[0]}, 33'h0);
   endtask : wait_idle

   task automatic fwrite(input logic [21:0] a, input logic [7:0] d);
      wr(fwsr_pkg::REG_ADDR, {10'h000, a});
      wr(fwsr_pkg::REG_WDATA, {24'h000000, d});
      wr(CT, 32'h1 << fwsr_pkg::CTRL_WRITE);
      wait_idle();
   endtask : fwrite

   initial begin
      logic [31:0] r;
      logic [7:0] d;
      logic [32:0] e;
      logic [32:0] ms;
      logic fl;
      ms = M_BSY | M_DN | M_FL | ERR;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      // idle after reset with the line released; stray offset refused
      rd(ST, M_RDY, ms | M_RDY);
      rd(8'h14, ERR, ERR | 33'h0FFFFFFFF);
      // one command and one poll per device behaviour in the table
      for (int i = 0; i < 5; i++) begin
         r = xs();
         d = (r[31:24] == 8'hF0) ? 8'h0F : r[31:24];
         flash.cfg_cnt = rc[i];
         flash.cfg_q5 = rq[i];
         flash.cfg_er = re[i];
         fwrite(r[21:0], d);
         check({11'h000, flash.wr_addr}, {11'h000, r[21:0]});
         wr(CT, 32'h1 << fwsr_pkg::CTRL_POLL);
         wait_idle();
         fl = rc[i] > 10;
         e = M_DN | M_GAP | (fl ? M_FL : 33'h0);
         if (fl && re[i]) e = e | M_WIN | M_TGB;
         if (!fl && d[3]) e = e | M_WIN;
         rd(ST, e, ms | M_WIN | M_GAP | M_TGB);
         e = M_DN | M_FL;
         wr(ST, e[31:0]);
         rd(ST, 33'h0, e);
         if (fl) begin
            fwrite(r[21:0], 8'hF0);
            rd(ST, M_RDY, M_RDY);
         end
      end
      // the gap flag lapses once the erase window time has passed
      repeat (2600) @(posedge clk_i);
      rd(ST, 33'h0, M_GAP);
      // endless toggling without a time limit: only abort ends the poll
      flash.cfg_cnt = 99999;
      flash.cfg_q5 = 1'b0;
      flash.cfg_er = 1'b0;
      fwrite(22'h000000, 8'h5A);
      wr(CT, 32'h1 << fwsr_pkg::CTRL_POLL);
      repeat (40) @(posedge clk_i);
      rd(ST, M_BSY, M_BSY | M_FL | M_RDY);
      wr(CT, 32'h1 << fwsr_pkg::CTRL_ABORT);
      wait_idle();
      rd(ST, 33'h0, M_FL);
      fwrite(22'h000000, 8'hF0);
      wr(CT, 32'h1 << fwsr_pkg::CTRL_READ);
      wait_idle();
      rd(fwsr_pkg::REG_RDATA, 33'h05A, ERR | 33'h0FF);
      close_out();
   end
endmodule : tb_fwsr_host
